/* File: rtl/mdi_notify.sv */
`timescale 1ns/1ps
`include "mdi_regs.svh"
module mdi_notify #(
  parameter int NAX = 4,
  parameter int DW  = 26
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Register port
  input  wire logic [3:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  // Host character stream
  input  wire logic [7:0]         rx_char,
  input  wire logic               rx_valid,
  // Queued commands from axis streams
  input  wire mdi_pkg::mdi_mode_t mode,
  input  wire mdi_pkg::mdi_cmd_t  cmd,
  input  wire logic [NAX-1:0]     cmd_axes,
  input  wire logic [NAX-1:0]     cmd_keep,
  input  wire logic [DW-1:0]      near_value,
  input  wire logic [NAX-1:0]     move_axes,
  input  wire logic               clear_cmd,
  input  wire logic               error_evt,
  // Axis motion state
  input  wire mdi_pkg::mdi_axis_t axis [NAX],
  // Host interrupt
  output logic                    irq
);
  initial begin
    if (NAX < 1 || NAX > 16) $error("mdi_notify: NAX out of range");
  end
  logic [NAX-1:0] done_flags;
  logic [NAX-1:0] pending;
  logic [NAX-1:0] joint_seen;
  logic [NAX-1:0] slip_flags;
  logic [NAX-1:0] part_axes;
  logic           sum_done;
  logic           err_flag;
  logic           near_flag;
  logic [3:0]     irq_ctrl;
  logic [15:0]    slip_tol;
  logic           flag_clear;
  logic [NAX-1:0] set_done;
  logic [NAX-1:0] near_in;
  logic [NAX-1:0] near_armed;
  logic [NAX-1:0] slip_hit;
  logic [NAX-1:0] slip_armed;
  logic           near_fire;
  logic           near_load;
  logic           peraxis_pulse;
  logic [NAX-1:0] next_joint;
  logic [NAX-1:0] hold_vec;
  logic [NAX-1:0] done_set;
  logic [3:0]     status;
  mdi_pkg::mdi_axis_stat_t st [NAX];

  // Immediate clear, never queued
  assign flag_clear = clear_cmd ||
    (rx_valid && rx_char == `MDI_CLEAR_CHAR) ||
    (rd && (addr == `MDI_ADDR_POLL_A ||
            addr == `MDI_ADDR_POLL_B));

  assign near_load = (cmd == mdi_pkg::MDI_CMD_NEAR);

  genvar g;
  generate
    for (g = 0; g < NAX; g++) begin : gen_ax
      mdi_axis_watch #(.DW(DW)) u_watch (
        .clk        (clk),
        .reset      (reset),
        .axis       (axis[g]),
        .in_move    (move_axes[g]),
        .near_load  (near_load && cmd_axes[g]),
        .near_keep  (cmd_keep[g]),
        .near_value (near_value),
        .near_fired (near_fire),
        .slip_arm   (cmd == mdi_pkg::MDI_CMD_SLIP && cmd_axes[g]),
        .stat       (st[g])
      );
      assign near_in[g]    = st[g].near_in;
      assign near_armed[g] = st[g].near_armed;
      assign slip_hit[g]   = st[g].slip_hit;
      assign slip_armed[g] = st[g].slip_armed;
      assign hold_vec[g]   = axis[g].hold_on;
      // Settled wait; without hold it is plain done
      assign set_done[g] = pending[g] &&
        (!axis[g].hold_on || axis[g].settled);
    end
  endgenerate

  // One interrupt once all axes of the move are within distance
  assign near_fire = |(near_armed & move_axes) &&
                     &(near_in | ~move_axes);

  // Participating axes per mode
  always_comb begin
    part_axes = cmd_axes;
    if (mode == mdi_pkg::MDI_SUBSET ||
        cmd == mdi_pkg::MDI_CMD_PERAXIS) begin
      part_axes = cmd_axes & move_axes;
    end
  end

  // Axes without hold complete at once, like plain done
  assign done_set = set_done |
    ((cmd == mdi_pkg::MDI_CMD_DONE ||
      cmd == mdi_pkg::MDI_CMD_PERAXIS) ? part_axes : '0) |
    ((cmd == mdi_pkg::MDI_CMD_SETTLED) ?
      (part_axes & ~hold_vec) : '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~set_done) |
        ((cmd == mdi_pkg::MDI_CMD_SETTLED) ?
          (part_axes & hold_vec) : '0);
    end
  end

  // Set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      done_flags <= '0;
    end else begin
      done_flags <= (flag_clear ? '0 : done_flags) | done_set;
    end
  end

  // New completions only, so a clear is not undone by stale bits
  always_comb begin
    next_joint = (flag_clear ? '0 : joint_seen) | done_set;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      joint_seen <= '0;
      sum_done   <= 1'b0;
    end else if (mode == mdi_pkg::MDI_JOINT_AXES) begin
      if (&next_joint) begin
        joint_seen <= '0;
        sum_done   <= 1'b1;
      end else begin
        joint_seen <= next_joint;
        sum_done   <= flag_clear ? 1'b0 : sum_done;
      end
    end else begin
      joint_seen <= '0;
      sum_done   <= (flag_clear ? 1'b0 : sum_done) | (|done_set);
    end
  end

  // Per-axis pulse gives a separate interrupt edge each command
  assign peraxis_pulse = (cmd == mdi_pkg::MDI_CMD_PERAXIS) && |part_axes;

  always_ff @(posedge clk) begin
    if (reset) begin
      err_flag   <= 1'b0;
      near_flag  <= 1'b0;
      slip_flags <= '0;
    end else begin
      err_flag   <= (err_flag && !flag_clear) || error_evt;
      near_flag  <= (near_flag && !flag_clear) || near_fire;
      slip_flags <= (flag_clear ? '0 : slip_flags) | slip_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ctrl <= `MDI_IRQ_CTRL_RST;
      slip_tol <= `MDI_SLIP_TOL_RST;
    end else if (wr) begin
      if (addr == `MDI_ADDR_IRQ_CTRL) begin
        irq_ctrl <= wdata[3:0];
      end
      if (addr == `MDI_ADDR_SLIP_TOL) begin
        slip_tol <= wdata[15:0];
      end
    end
  end

  assign status = {|slip_flags, near_flag, err_flag, sum_done};

  // Interrupt held while enabled flags stay set, except the done flag in a per-axis command cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_ctrl[`MDI_IC_DONE] && sum_done && !peraxis_pulse) ||
             (irq_ctrl[`MDI_IC_ERROR] && err_flag) ||
             (irq_ctrl[`MDI_IC_NEAR] && near_flag) ||
             (irq_ctrl[`MDI_IC_SLIP] && |slip_flags);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        `MDI_ADDR_STATUS,
        `MDI_ADDR_POLL_A:   rdata <= {28'h0, status};
        `MDI_ADDR_DONE,
        `MDI_ADDR_POLL_B:   rdata <= 32'(done_flags);
        `MDI_ADDR_NEAR_ERR: rdata <= 32'(near_armed);
        `MDI_ADDR_SLIP:     rdata <= {16'h0, 8'(slip_armed), 8'(slip_flags)};
        `MDI_ADDR_IRQ_CTRL: rdata <= {28'h0, irq_ctrl};
        `MDI_ADDR_SLIP_TOL: rdata <= {16'h0, slip_tol};
        default:            rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

/* File: rtl/mdi_regs.svh */
`ifndef MDI_REGS_SVH
`define MDI_REGS_SVH
`define MDI_CLEAR_CHAR     8'h19
`define MDI_ADDR_STATUS    4'h0
`define MDI_ADDR_DONE      4'h1
`define MDI_ADDR_NEAR_ERR  4'h2
`define MDI_ADDR_SLIP      4'h3
`define MDI_ADDR_IRQ_CTRL  4'h4
`define MDI_ADDR_SLIP_TOL  4'h5
`define MDI_ADDR_POLL_A    4'h6
`define MDI_ADDR_POLL_B    4'h7
`define MDI_ADDR_NEAR_DIST 4'h8
`define MDI_ST_DONE        0
`define MDI_ST_ERROR       1
`define MDI_ST_NEAR        2
`define MDI_ST_SLIP        3
`define MDI_IC_DONE        0
`define MDI_IC_ERROR       1
`define MDI_IC_NEAR        2
`define MDI_IC_SLIP        3
`define MDI_IRQ_CTRL_RST   4'h0
`define MDI_SLIP_TOL_RST   16'h0001
`define MDI_NEAR_MAX       33544431
`endif

/* File: rtl/mdi_pkg.sv */
package mdi_pkg;
  typedef enum logic [1:0] {
    MDI_ONE_SHAFT  = 2'b00,
    MDI_JOINT_AXES = 2'b01,
    MDI_SUBSET     = 2'b10
  } mdi_mode_t;
  typedef enum logic [2:0] {
    MDI_CMD_NONE    = 3'b000,
    MDI_CMD_DONE    = 3'b001,
    MDI_CMD_PERAXIS = 3'b010,
    MDI_CMD_SETTLED = 3'b011,
    MDI_CMD_SLIP    = 3'b100,
    MDI_CMD_NEAR    = 3'b101
  } mdi_cmd_t;
  typedef struct packed {
    logic        decel;
    logic        settled;
    logic        hold_on;
    logic        slip;
    logic        disarm;
    logic [25:0] remaining;
    logic [25:0] ramp_down;
  } mdi_axis_t;
  typedef struct packed {
    logic       near_armed;
    logic       near_in;
    logic       slip_armed;
    logic       slip_hit;
  } mdi_axis_stat_t;
endpackage

/* File: rtl/mdi_axis_watch.sv */
`timescale 1ns/1ps
`include "mdi_regs.svh"
module mdi_axis_watch #(
  parameter int DW = 26
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Axis motion state
  input  wire mdi_pkg::mdi_axis_t axis,
  input  wire logic               in_move,
  // Near distance load
  input  wire logic               near_load,
  input  wire logic               near_keep,
  input  wire logic [DW-1:0]      near_value,
  input  wire logic               near_fired,
  // Slip arm
  input  wire logic               slip_arm,
  // Status
  output mdi_pkg::mdi_axis_stat_t stat
);
  initial begin
    if (DW < 26) $error("mdi_axis_watch: distance too narrow");
  end
  logic [DW-1:0] near_dist;
  logic          near_armed;
  logic          slip_armed;
  logic [DW-1:0] dist_abs;

  assign dist_abs = near_dist[DW-1] ? DW'(-near_dist) : near_dist;

  always_ff @(posedge clk) begin
    if (reset) begin
      near_dist <= '0;
    end else if (near_load && !near_keep) begin
      near_dist <= near_value;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      near_armed <= 1'b0;
    end else if (near_load) begin
      near_armed <= 1'b1;
    end else if (near_fired) begin
      near_armed <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slip_armed <= 1'b0;
    end else if (slip_arm) begin
      slip_armed <= 1'b1;
    end else if (axis.disarm || axis.slip) begin
      slip_armed <= 1'b0;
    end
  end

  // Axis not in the move counts as within
  assign stat.near_in = !in_move ||
    (axis.decel && (axis.remaining <= dist_abs ||
                    dist_abs > axis.ramp_down));
  assign stat.near_armed = near_armed;
  assign stat.slip_armed = slip_armed;
  assign stat.slip_hit   = slip_armed && axis.slip;
endmodule

/* File: dv/mdi_notify_assertions.sv */
`timescale 1ns/1ps
module mdi_notify_chk #(
  parameter int NAX = 4,
  parameter int DW  = 26
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               reset,
  // Register port
  input wire logic [3:0]         addr,
  input wire logic [31:0]        wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [31:0]        rdata,
  // Commands and events
  input wire logic [7:0]         rx_char,
  input wire logic               rx_valid,
  input wire mdi_pkg::mdi_mode_t mode,
  input wire mdi_pkg::mdi_cmd_t  cmd,
  input wire logic [NAX-1:0]     cmd_axes,
  input wire logic               error_evt,
  input wire mdi_pkg::mdi_axis_t axis [NAX],
  // Host interrupt
  input wire logic               irq
);
  logic [3:0] ctrl;
  logic       tol_set;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of the interrupt enables
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl    <= 4'h0;
      tol_set <= 1'b0;
    end else if (wr && addr == 4'h4) begin
      ctrl <= wdata[3:0];
    end else if (wr && addr == 4'h5) begin
      tol_set <= 1'b1;
    end
  end
  a_clear_char: assert property (
    rx_valid && rx_char == 8'h19 && cmd == mdi_pkg::MDI_CMD_NONE
    && !error_evt && !wr && ctrl[3:2] == 2'h0 |-> ##2 !irq)
    else $error("irq held after clear character");
  a_poll_clear: assert property (
    rd && addr[3:1] == 3'h3 && cmd == mdi_pkg::MDI_CMD_NONE && !error_evt
    ##1 rd && addr == 4'h0 |=> rdata[1:0] == 2'h0)
    else $error("flags survive a poll");
  a_done_irq: assert property (
    cmd == mdi_pkg::MDI_CMD_DONE && mode == mdi_pkg::MDI_ONE_SHAFT
    && cmd_axes != '0 && ctrl[0] && !wr |-> ##2 irq)
    else $error("done without interrupt");
  a_irq_gated: assert property (
    ctrl == 4'h0 && $past(ctrl) == 4'h0 |-> !irq)
    else $error("interrupt while all disabled");
  a_tol_default: assert property (
    rd && addr == 4'h5 && !tol_set |=> rdata == 32'h1)
    else $error("slip tolerance default wrong");
  a_settled_plain: assert property (
    cmd == mdi_pkg::MDI_CMD_SETTLED && mode == mdi_pkg::MDI_ONE_SHAFT
    && cmd_axes[0] && !axis[0].hold_on && ctrl[0] && !wr |-> ##2 irq)
    else $error("settled without hold not immediate");
  a_error_irq: assert property (
    error_evt && ctrl[1] && !wr |-> ##2 irq)
    else $error("error flag without interrupt");
  a_unmapped: assert property (rd && addr > 4'h8 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind mdi_notify mdi_notify_chk #(.NAX(NAX), .DW(DW)) u_chk (
  .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .rx_char, .rx_valid,
  .mode, .cmd, .cmd_axes, .error_evt, .axis, .irq
);

/* File: dv/mdi_host.sv */
`timescale 1ns/1ps
module mdi_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic [3:0]       addr,
  output logic [31:0]      wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr  = 4'h0;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  task automatic write(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Two back-to-back reads, data of the second returned
  task automatic read(input logic [3:0] a0, a1, output logic [31:0] d);
    addr <= a0;
    rd   <= 1'b1;
    @(posedge clk);
    addr <= a1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

/* File: dv/test_motion_done_interrupt_flags.sv */
`timescale 1ns/1ps
module test_motion_done_interrupt_flags;
  logic               clk, reset, wr, rd, rx_valid, clear_cmd, error_evt;
  logic               irq;
  logic [3:0]         addr, cmd_axes, cmd_keep, move_axes, r;
  logic [31:0]        wdata, rdata, q;
  logic [7:0]         rx_char;
  logic [25:0]        near_value;
  mdi_pkg::mdi_mode_t mode;
  mdi_pkg::mdi_cmd_t  cmd;
  mdi_pkg::mdi_axis_t axis [4];
  int                 seed, fail_count, cmp_count, cyc;
  mdi_notify #(.NAX(4), .DW(26)) dut (
    .clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .rx_char, .rx_valid,
    .mode, .cmd, .cmd_axes, .cmd_keep, .near_value, .move_axes,
    .clear_cmd, .error_evt, .axis, .irq
  );
  mdi_host host (.clk, .addr, .wdata, .wr, .rd, .rdata);
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  task automatic check(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic issue(input mdi_pkg::mdi_cmd_t c, input logic [3:0] a);
    cmd      <= c;
    cmd_axes <= a;
    @(posedge clk);
    cmd <= mdi_pkg::MDI_CMD_NONE;
    repeat (3) @(posedge clk);
  endtask
  // Bit 0 character, bit 1 clear command, bit 2 error event
  task automatic evt(input logic [2:0] k);
    rx_valid  <= k[0];
    clear_cmd <= k[1];
    error_evt <= k[2];
    @(posedge clk);
    {error_evt, clear_cmd, rx_valid} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    {seed, fail_count, cmp_count, cyc} = {32'd41, 96'd0};
    {reset, rx_valid, clear_cmd, error_evt} = 4'h8;
    {rx_char, cmd_axes, cmd_keep, near_value, move_axes} = '0;
    mode = mdi_pkg::MDI_ONE_SHAFT;
    cmd = mdi_pkg::MDI_CMD_NONE;
    foreach (axis[i]) axis[i] = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    host.read(4'h5, 4'h5, q);
    check("slip_tol", q, 32'h1);
    host.read(4'hc, 4'hc, q);
    check("unmapped", q, 32'h0);
    issue(mdi_pkg::MDI_CMD_DONE, 4'h1);
    check("irq_masked", irq, 32'h0);
    host.read(4'h1, 4'h1, q);
    check("done_bits", q, 32'h1);
    host.read(4'h7, 4'h0, q);
    check("poll_status", q[1:0], 32'h0);
    host.read(4'h1, 4'h1, q);
    check("poll_done_bits", q, 32'h0);
    host.write(4'h4, 32'h1);
    issue(mdi_pkg::MDI_CMD_DONE, 4'h2);
    check("irq_done", irq, 32'h1);
    rx_char <= 8'($random(seed)) | 8'h80;
    evt(3'h1);
    check("irq_other_char", irq, 32'h1);
    rx_char <= 8'h19;
    evt(3'h1);
    check("irq_clear_char", irq, 32'h0);
    mode <= mdi_pkg::MDI_JOINT_AXES;
    repeat (4) begin
      r = (4'($random(seed)) & 4'h7) | 4'h1;
      issue(mdi_pkg::MDI_CMD_DONE, r);
      host.read(4'h1, 4'h1, q);
      check("joint_bits", q, {28'h0, r});
      host.read(4'h0, 4'h0, q);
      check("joint_partial", q[0], 32'h0);
      issue(mdi_pkg::MDI_CMD_DONE, ~r);
      host.read(4'h0, 4'h0, q);
      check("joint_summary", q[0], 32'h1);
      evt(3'h2);
      host.read(4'h1, 4'h1, q);
      check("clear_cmd", q, 32'h0);
    end
    mode <= mdi_pkg::MDI_SUBSET;
    move_axes <= 4'h6;
    issue(mdi_pkg::MDI_CMD_DONE, 4'hf);
    host.read(4'h1, 4'h1, q);
    check("subset_bits", q, 32'h6);
    evt(3'h2);
    mode <= mdi_pkg::MDI_ONE_SHAFT;
    host.write(4'h4, 32'h2);
    evt(3'h4);
    check("irq_error", irq, 32'h1);
    evt(3'h1);
    check("error_cleared", irq, 32'h0);
    host.write(4'h4, 32'h1);
    axis[0].hold_on <= 1'b1;
    issue(mdi_pkg::MDI_CMD_SETTLED, 4'h1);
    check("irq_unsettled", irq, 32'h0);
    axis[0].settled <= 1'b1;
    repeat (3) @(posedge clk);
    check("irq_settled", irq, 32'h1);
    evt(3'h2);
    axis[0] <= '0;
    issue(mdi_pkg::MDI_CMD_SETTLED, 4'h1);
    check("irq_no_hold", irq, 32'h1);
    evt(3'h2);
    host.write(4'h4, 32'h4);
    move_axes <= 4'h1;
    near_value <= 26'(($random(seed) & 32'h3ff) + 32'h60);
    issue(mdi_pkg::MDI_CMD_NEAR, 4'h1);
    axis[0].remaining <= 26'd50;
    axis[0].ramp_down <= 26'd20;
    repeat (3) @(posedge clk);
    check("near_no_decel", irq, 32'h0);
    axis[0].decel <= 1'b1;
    repeat (3) @(posedge clk);
    check("near_decel", irq, 32'h1);
    host.write(4'h4, 32'h8);
    repeat (2) @(posedge clk);
    check("slip_unarmed", irq, 32'h0);
    issue(mdi_pkg::MDI_CMD_SLIP, 4'h1);
    axis[0].slip <= 1'b1;
    repeat (3) @(posedge clk);
    check("slip_irq", irq, 32'h1);
    evt(3'h2);
    host.write(4'h4, 32'h1);
    mode <= mdi_pkg::MDI_SUBSET;
    move_axes <= 4'h5;
    issue(mdi_pkg::MDI_CMD_PERAXIS, 4'hf);
    host.read(4'h1, 4'h1, q);
    check("peraxis_bits", q, 32'h5);
    check("irq_peraxis", irq, 32'h1);
    test_done;
  end
endmodule
